// file: rtl/frame_exposure_timing_ctrl.sv
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module frame_exposure_timing_ctrl
    import fetc_pkg::*;
#(
    parameter int DUMMY_W = 4
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RSTN,
    fetc_link_if.sensor_mp  LINK,
    output      logic       EXPOSE_L,
    output      logic       EXPOSE_S,
    output      logic       SHUTTER_CLOSE,
    output      logic       READOUT,
    output      logic       LINE_VALID,
    output      logic       FRAME_START,
    output      logic [3:0] SHORT_COLS,
    output      logic [7:0] SEQ_REMAINING
);
    if (DUMMY_W < 1 || DUMMY_W > 8) begin : g_chk
        $error("frame_exposure_timing_ctrl: DUMMY_W out of range");
    end

    typedef struct packed {
        logic [2:0]         mode;
        logic [13:0]        tick_len;
        logic [7:0]         nframes;
        logic [15:0]        frame_ticks;
        logic               dual;
        logic [15:0]        exp_l;
        logic [15:0]        exp_s;
        logic               pairing;
        logic [13:0]        row_len;
        logic [12:0]        win_rows;
        logic [DUMMY_W-1:0] dummies;
        logic [7:0]         gran;
        logic               req_reg;
        logic               req_q;
        logic [7:0]         rem;
        logic               frame_run;
        logic [15:0]        frame_cnt;
        logic               l_on;
        logic               s_on;
        logic [15:0]        cnt_l;
        logic [15:0]        cnt_s;
        phase_t             phase;
        logic [15:0]        glob_cnt;
        logic [15:0]        row_cnt;
        logic               pipe;
        logic               go;
        logic               line_valid;
        logic [3:0]         short_cols;
        logic [15:0]        rdata;
    } dev_state_t;

    localparam dev_state_t DEV_RST = '{
        mode: MODE_RST, tick_len: TICK_RST, nframes: NFRM_RST, frame_ticks: FRAME_RST,
        exp_l: EXPL_RST, exp_s: EXPS_RST, row_len: ROWLEN_RST, win_rows: WINROWS_RST,
        dummies: DUMMY_W'(PIPEDUM_RST), gran: GRAN_RST, phase: PH_IDLE, default: '0};

    dev_state_t s_q;
    dev_state_t s_d;
    logic       tick;
    logic       row_tick;
    logic       row_restart;

    // =========================================================
    // tick and row dividers
    tick_divider #(.W(14)) u_tick (
        .clk_sys (CLK_SYS),
        .rstn    (RSTN),
        .restart (s_d.go),
        .len     (s_q.tick_len),
        .pulse   (tick)
    );

    tick_divider #(.W(14)) u_row (
        .clk_sys (CLK_SYS),
        .rstn    (RSTN),
        .restart (row_restart),
        .len     (s_q.row_len),
        .pulse   (row_tick)
    );

    // =========================================================
    // next state
    logic        req_now;
    logic        rise;
    logic        fall;
    logic        ext0;
    logic        period_end;
    logic [7:0]  rem_sum;
    logic        start_s;
    logic        l_keep;
    logic        s_keep;
    logic        glob_start;
    logic [15:0] total_rows;

    always_comb begin
        s_d          = s_q;
        s_d.go       = 1'b0;
        s_d.line_valid = 1'b0;
        row_restart  = 1'b0;
        req_now      = LINK.exp_req | s_q.req_reg;
        rise         = req_now & ~s_q.req_q;
        fall         = ~req_now & s_q.req_q;
        s_d.req_q    = req_now;
        ext0         = (s_q.mode == MODE_FULL_EXT);
        rem_sum      = s_q.rem;
        period_end   = s_q.frame_run && tick && (s_q.frame_cnt + 16'h1 >= s_q.frame_ticks);

        // sensor register writes
        if (LINK.cfg_we) begin
            case (LINK.cfg_addr)
                REG_MODE:    s_d.mode        = LINK.cfg_wdata[2:0];
                REG_TICK:    s_d.tick_len    = LINK.cfg_wdata[13:0];
                REG_NFRM:    s_d.nframes     = LINK.cfg_wdata[7:0];
                REG_FRAME:   s_d.frame_ticks = LINK.cfg_wdata;
                REG_DUAL:    s_d.dual        = LINK.cfg_wdata[0];
                REG_EXPL:    s_d.exp_l       = LINK.cfg_wdata;
                REG_EXPS:    s_d.exp_s       = LINK.cfg_wdata;
                REG_ROWLEN:  s_d.row_len     = LINK.cfg_wdata[13:0];
                REG_PAIR:    s_d.pairing     = LINK.cfg_wdata[0];
                REG_WINROWS: s_d.win_rows    = LINK.cfg_wdata[12:0];
                REG_PIPEDUM: s_d.dummies     = LINK.cfg_wdata[DUMMY_W-1:0];
                REG_GRAN:    s_d.gran        = LINK.cfg_wdata[7:0];
                REG_REQ:     s_d.req_reg     = LINK.cfg_wdata[0];
                default: ;
            endcase
        end

        // frame start per mode
        case (s_q.mode)
            MODE_FULL_EXT, MODE_PROG_EXT: begin
                s_d.go = rise;
            end
            MODE_TRIG_INT: begin
                rem_sum = s_q.rem + (rise ? s_q.nframes : 8'h00);
                s_d.go  = (rem_sum != 8'h00) && (!s_q.frame_run || period_end);
            end
            MODE_STREAM_INT: begin
                s_d.go = !s_q.frame_run || period_end;
            end
            default: begin
                s_d.go = 1'b0;
            end
        endcase
        s_d.rem = (s_q.mode == MODE_TRIG_INT) ? rem_sum - 8'(s_d.go) : s_q.rem;

        // frame period counter for internal modes
        if (s_d.go) begin
            s_d.frame_cnt = 16'h0;
            s_d.frame_run = (s_q.mode == MODE_TRIG_INT) || (s_q.mode == MODE_STREAM_INT);
        end else if (period_end) begin
            s_d.frame_run = 1'b0;
        end else if (s_q.frame_run && tick) begin
            s_d.frame_cnt = s_q.frame_cnt + 16'h1;
        end

        // exposure countdown in ticks
        l_keep = s_q.l_on && !(ext0 && rise);
        s_keep = s_q.s_on && !(ext0 && rise);
        if (!ext0 && s_q.l_on && tick) begin
            l_keep    = (s_q.cnt_l > 16'h1);
            s_d.cnt_l = s_q.cnt_l - 16'h1;
        end
        if (!ext0 && s_q.s_on && tick) begin
            s_keep    = (s_q.cnt_s > 16'h1);
            s_d.cnt_s = s_q.cnt_s - 16'h1;
        end
        glob_start = (s_q.l_on || s_q.s_on) && !(l_keep || s_keep);
        s_d.l_on   = l_keep;
        s_d.s_on   = s_keep;
        start_s    = ext0 ? (s_q.dual ? fall : rise) : s_d.go;
        if (s_d.go) begin
            s_d.l_on  = 1'b1;
            s_d.cnt_l = s_q.exp_l;
        end
        if (start_s) begin
            s_d.s_on  = 1'b1;
            s_d.cnt_s = s_q.dual ? s_q.exp_s : s_q.exp_l;
        end

        // shutter close and readout; short frames are not flagged
        total_rows = 16'(FIXED_DUMMY_ROWS) + 16'(s_q.win_rows)
                   + (s_q.pipe ? 16'(s_q.dummies) << 1 : 16'h0);
        case (s_q.phase)
            PH_GLOB: begin
                if (s_q.glob_cnt <= 16'h1) begin
                    s_d.phase   = PH_READ;
                    s_d.row_cnt = 16'h0;
                    s_d.pipe    = 1'b0;
                    row_restart = 1'b1;
                end else begin
                    s_d.glob_cnt = s_q.glob_cnt - 16'h1;
                end
            end
            PH_READ: begin
                if (s_d.go) begin
                    s_d.pipe = 1'b1;
                end
                if (row_tick) begin
                    s_d.row_cnt    = s_q.row_cnt + 16'h1;
                    s_d.line_valid = (s_d.row_cnt >= 16'(FIXED_DUMMY_ROWS))
                                  && (s_d.row_cnt < 16'(FIXED_DUMMY_ROWS) + 16'(s_q.win_rows));
                    if (s_q.row_cnt + 16'h1 >= total_rows) begin
                        s_d.phase = PH_IDLE;
                    end
                end
            end
            default: begin
                s_d.phase = PH_IDLE;
            end
        endcase
        if (glob_start) begin
            s_d.phase    = PH_GLOB;
            s_d.glob_cnt = glob_cycles(s_q.gran);
        end

        s_d.short_cols = short_mask(s_q.dual, s_q.pairing);

        // read back
        case (LINK.cfg_addr)
            REG_MODE:    s_d.rdata = {13'h0, s_q.mode};
            REG_TICK:    s_d.rdata = {2'h0, s_q.tick_len};
            REG_NFRM:    s_d.rdata = {8'h0, s_q.nframes};
            REG_FRAME:   s_d.rdata = s_q.frame_ticks;
            REG_DUAL:    s_d.rdata = {15'h0, s_q.dual};
            REG_EXPL:    s_d.rdata = s_q.exp_l;
            REG_EXPS:    s_d.rdata = s_q.exp_s;
            REG_ROWLEN:  s_d.rdata = {2'h0, s_q.row_len};
            REG_PAIR:    s_d.rdata = {15'h0, s_q.pairing};
            REG_WINROWS: s_d.rdata = {3'h0, s_q.win_rows};
            REG_PIPEDUM: s_d.rdata = 16'(s_q.dummies);
            REG_GRAN:    s_d.rdata = {8'h0, s_q.gran};
            REG_REQ:     s_d.rdata = {7'h0, s_q.rem, s_q.req_reg};
            default:     s_d.rdata = 16'h0;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            s_q <= DEV_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // outputs
    assign LINK.cfg_rdata  = s_q.rdata;
    assign EXPOSE_L        = s_q.l_on;
    assign EXPOSE_S        = s_q.s_on;
    assign SHUTTER_CLOSE   = (s_q.phase == PH_GLOB);
    assign READOUT         = (s_q.phase == PH_READ);
    assign LINE_VALID      = s_q.line_valid;
    assign FRAME_START     = s_q.go;
    assign SHORT_COLS      = s_q.short_cols;
    assign SEQ_REMAINING   = s_q.rem;
endmodule : frame_exposure_timing_ctrl

// file: rtl/fetc_pkg.sv
package fetc_pkg;

    // =========================================================
    // sensor register offsets
    localparam logic [6:0] REG_MODE     = 7'h09;
    localparam logic [6:0] REG_TICK     = 7'h0a;
    localparam logic [6:0] REG_NFRM     = 7'h0c;
    localparam logic [6:0] REG_FRAME    = 7'h0d;
    localparam logic [6:0] REG_DUAL     = 7'h0f;
    localparam logic [6:0] REG_EXPL     = 7'h10;
    localparam logic [6:0] REG_EXPS     = 7'h12;
    localparam logic [6:0] REG_ROWLEN   = 7'h16;
    localparam logic [6:0] REG_PAIR     = 7'h76;
    localparam logic [6:0] REG_WINROWS  = 7'h7a;
    localparam logic [6:0] REG_PIPEDUM  = 7'h7b;
    localparam logic [6:0] REG_GRAN     = 7'h7c;
    localparam logic [6:0] REG_REQ      = 7'h7d;

    // =========================================================
    // reset values
    localparam logic [2:0]  MODE_RST    = 3'h0;
    localparam logic [13:0] TICK_RST    = 14'h0045;
    localparam logic [7:0]  NFRM_RST    = 8'h01;
    localparam logic [15:0] FRAME_RST   = 16'hc350;
    localparam logic [15:0] EXPL_RST    = 16'h2710;
    localparam logic [15:0] EXPS_RST    = 16'h2710;
    localparam logic [13:0] ROWLEN_RST  = 14'h0172;
    localparam logic [12:0] WINROWS_RST = 13'h1774;
    localparam logic [7:0]  GRAN_RST    = 8'h45;
    localparam logic [3:0]  PIPEDUM_RST = 4'h5;

    // =========================================================
    // control modes
    localparam logic [2:0] MODE_FULL_EXT   = 3'h0;
    localparam logic [2:0] MODE_PROG_EXT   = 3'h1;
    localparam logic [2:0] MODE_TRIG_INT   = 3'h2;
    localparam logic [2:0] MODE_STREAM_INT = 3'h3;

    // =========================================================
    // timing
    localparam int FIXED_DUMMY_ROWS = 5;
    localparam int GLOB_FACTOR      = 150;
    localparam int ADC_PER_PIX      = 12;
    localparam int CLK_MHZ          = 100;
    localparam int MIN_EXP_US       = 100;
    localparam logic [29:0] MIN_EXP_CYC = 30'(MIN_EXP_US * CLK_MHZ);

    // =========================================================
    // host wishbone offsets
    localparam logic [3:0] WB_CMD   = 4'h0;
    localparam logic [3:0] WB_RDSEL = 4'h4;
    localparam logic [3:0] WB_TRIG  = 4'h8;
    localparam logic [3:0] WB_STAT  = 4'hc;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_GLOB = 2'b01,
        PH_READ = 2'b10
    } phase_t;

    // short-group column mask for columns 0..3 of each group of four
    function automatic logic [3:0] short_mask(input logic dual, input logic pair);
        if (!dual) begin
            return 4'h0;
        end
        return pair ? 4'h3 : 4'h5;
    endfunction : short_mask

    // shutter-close length in system clock cycles
    function automatic logic [15:0] glob_cycles(input logic [7:0] gran);
        return 16'(GLOB_FACTOR * ADC_PER_PIX * int'(gran) / ADC_PER_PIX);
    endfunction : glob_cycles

endpackage : fetc_pkg

// file: rtl/fetc_link_if.sv
`timescale 1ns/1ps
interface fetc_link_if;
    logic [6:0]  cfg_addr;
    logic [15:0] cfg_wdata;
    logic        cfg_we;
    logic [15:0] cfg_rdata;
    logic        exp_req;

    modport sensor_mp (input cfg_addr, input cfg_wdata, input cfg_we, input exp_req,
                       output cfg_rdata);
    modport ctrl_mp   (output cfg_addr, output cfg_wdata, output cfg_we, output exp_req,
                       input cfg_rdata);
endinterface : fetc_link_if

// file: rtl/tick_divider.sv
`timescale 1ns/1ps
module tick_divider #(
    parameter int W = 14
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic         restart,
    input  wire logic [W-1:0] len,
    output      logic         pulse
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;
    logic       wrap;

    if (W < 2 || W > 16) begin : g_chk
        $error("tick_divider: W out of range");
    end

    // pulse marks the last cycle of each period, so users react on the period edge
    always_comb begin
        s_d  = s_q;
        wrap = (s_q.cnt + W'(1) >= len);
        if (restart) begin
            s_d.cnt = '0;
        end else if (wrap) begin
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pulse = wrap;
endmodule : tick_divider

// file: rtl/camera_ctrl_host.sv
`timescale 1ns/1ps
module camera_ctrl_host
    import fetc_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output      logic [31:0] WB_DAT_O,
    output      logic        WB_ACK_O,
    fetc_link_if.ctrl_mp     LINK
);
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
        logic [6:0]  addr;
        logic [15:0] wdata;
        logic        we;
        logic        req;
        logic        refused;
        logic [13:0] tick_len;
    } host_state_t;

    localparam host_state_t HOST_RST = '{tick_len: TICK_RST, default: '0};

    host_state_t s_q;
    host_state_t s_d;
    logic        take;
    logic        bad;
    logic [6:0]  c_addr;
    logic [15:0] c_data;
    logic [29:0] exp_cyc;

    // =========================================================
    // wishbone slave and command issue
    always_comb begin
        s_d     = s_q;
        s_d.we  = 1'b0;
        s_d.ack = 1'b0;
        take    = WB_CYC_I && WB_STB_I && !s_q.ack;
        c_addr  = WB_DAT_I[6:0];
        c_data  = WB_DAT_I[31:16];
        exp_cyc = 30'(c_data) * 30'(s_q.tick_len);
        bad     = (((c_addr == REG_EXPL) || (c_addr == REG_EXPS))
                   && (exp_cyc < MIN_EXP_CYC))
               || ((c_addr == REG_NFRM) && (c_data[7:0] == 8'h00));
        if (take) begin
            s_d.ack = 1'b1;
            case (WB_ADR_I)
                WB_CMD: begin
                    s_d.dat = 32'h0;
                    if (WB_WE_I && WB_SEL_I == 4'hf) begin
                        s_d.refused = bad;
                        if (!bad) begin
                            s_d.addr  = c_addr;
                            s_d.wdata = c_data;
                            s_d.we    = 1'b1;
                            if (c_addr == REG_TICK) begin
                                s_d.tick_len = c_data[13:0];
                            end
                        end
                    end
                end
                WB_RDSEL: begin
                    s_d.dat = {16'h0, LINK.cfg_rdata};
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        s_d.addr = WB_DAT_I[6:0];
                    end
                end
                WB_TRIG: begin
                    s_d.dat = {31'h0, s_q.req};
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        s_d.req = WB_DAT_I[0];
                    end
                end
                WB_STAT: begin
                    s_d.dat = {31'h0, s_q.refused};
                end
                default: begin
                    s_d.dat = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            s_q <= HOST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // outputs
    assign WB_ACK_O       = s_q.ack;
    assign WB_DAT_O       = s_q.dat;
    assign LINK.cfg_addr  = s_q.addr;
    assign LINK.cfg_wdata = s_q.wdata;
    assign LINK.cfg_we    = s_q.we;
    assign LINK.exp_req   = s_q.req;
endmodule : camera_ctrl_host

// file: verif/fetc_chk.sv
`timescale 1ns/1ps
module fetc_chk
    import fetc_pkg::*;
(
    input wire logic        CLK_SYS,
    input wire logic        RSTN,
    input wire logic [6:0]  cfg_addr,
    input wire logic [15:0] cfg_wdata,
    input wire logic        cfg_we,
    input wire logic [15:0] cfg_rdata,
    input wire logic        exp_req
);
    // ====================
    // shadow of accepted writes
    logic [13:0] tick_q;
    logic [15:0] frame_q;
    logic [15:0] expl_q;
    logic [15:0] exps_q;
    logic [2:0]  mode_q;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            tick_q  <= TICK_RST;
            frame_q <= FRAME_RST;
            expl_q  <= EXPL_RST;
            exps_q  <= EXPS_RST;
            mode_q  <= MODE_RST;
        end else if (cfg_we) begin
            case (cfg_addr)
                REG_TICK:  tick_q <= cfg_wdata[13:0];
                REG_FRAME: frame_q <= cfg_wdata;
                REG_EXPL:  expl_q <= cfg_wdata;
                REG_EXPS:  exps_q <= cfg_wdata;
                REG_MODE:  mode_q <= cfg_wdata[2:0];
                default:   mode_q <= mode_q;
            endcase
        end
    end
    // ====================
    // assertions
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    property rd_p(logic [6:0] a, logic [15:0] v);
        cfg_addr == a && $past(cfg_addr) == a && !$past(cfg_we) && !$past(cfg_we, 2)
            |-> cfg_rdata == v;
    endproperty
    tick_read_a: assert property (rd_p(REG_TICK, {2'h0, tick_q}))
        else $error("tick length readback wrong");
    frame_read_a: assert property (rd_p(REG_FRAME, frame_q))
        else $error("frame period readback wrong");
    expl_read_a: assert property (rd_p(REG_EXPL, expl_q))
        else $error("long exposure readback wrong");
    exps_read_a: assert property (rd_p(REG_EXPS, exps_q))
        else $error("short exposure readback wrong");
    mode_read_a: assert property (rd_p(REG_MODE, {13'h0, mode_q}))
        else $error("control mode readback wrong");
    expl_min_a: assert property (cfg_we && cfg_addr == REG_EXPL
        |-> 30'(cfg_wdata) * 30'(tick_q) >= MIN_EXP_CYC)
        else $error("long exposure below minimum sent");
    exps_min_a: assert property (cfg_we && cfg_addr == REG_EXPS
        |-> 30'(cfg_wdata) * 30'(tick_q) >= MIN_EXP_CYC)
        else $error("short exposure below minimum sent");
    nfrm_range_a: assert property (cfg_we && cfg_addr == REG_NFRM
        |-> cfg_wdata[7:0] != 8'h00)
        else $error("zero frame count sent");
    cover property (cfg_we && cfg_addr == REG_MODE && cfg_wdata[2:0] == MODE_STREAM_INT);
    cover property ($rose(exp_req));
    cover property (cfg_we && cfg_addr == REG_EXPS);
endmodule : fetc_chk

// file: verif/frame_exposure_timing_ctrl_bench.sv
`timescale 1ns/1ps
module frame_exposure_timing_ctrl_bench;
    import fetc_pkg::*;
    // ====================
    // signals and instances
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic        ack, exp_l, exp_s, shut, rdout, lv, fs;
    logic [3:0]  cols;
    logic [7:0]  rem;
    int          errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    fetc_link_if link ();
    camera_ctrl_host u_camera_ctrl_host (.CLK_SYS(clk_sys), .RSTN(rstn), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .LINK(link));
    frame_exposure_timing_ctrl u_frame_exposure_timing_ctrl (.CLK_SYS(clk_sys), .RSTN(rstn),
        .LINK(link), .EXPOSE_L(exp_l), .EXPOSE_S(exp_s), .SHUTTER_CLOSE(shut),
        .READOUT(rdout), .LINE_VALID(lv), .FRAME_START(fs), .SHORT_COLS(cols),
        .SEQ_REMAINING(rem));
    fetc_chk u_fetc_chk (.CLK_SYS(clk_sys), .RSTN(rstn), .cfg_addr(link.cfg_addr),
        .cfg_wdata(link.cfg_wdata), .cfg_we(link.cfg_we), .cfg_rdata(link.cfg_rdata),
        .exp_req(link.exp_req));
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            errors++;
            end_sim();
        end
    end
    // ====================
    // shared tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic cmd(input logic [6:0] a, input logic [15:0] d);
        logic [31:0] q;
        wb(WB_CMD, 1'b1, {d, 9'h0, a}, q);
    endtask : cmd
    task automatic sread(input logic [6:0] a, output logic [31:0] q);
        wb(WB_RDSEL, 1'b1, {25'h0, a}, q);
        repeat (2) @(posedge clk_sys);
        wb(WB_RDSEL, 1'b0, 32'h0, q);
    endtask : sread
    task automatic trig(input logic v);
        logic [31:0] q;
        wb(WB_TRIG, 1'b1, {31'h0, v}, q);
        repeat (4) @(posedge clk_sys);
    endtask : trig
    function automatic logic sig(input int k);
        case (k)
            1: return exp_l;
            2: return exp_s;
            3: return shut;
            default: return rdout;
        endcase
    endfunction : sig
    task automatic hi_len(input int k, output int n, output int p);
        n = 0;
        p = 0;
        while (sig(k) !== 1'b1) @(posedge clk_sys);
        while (sig(k) === 1'b1) begin
            n++;
            p += int'(lv === 1'b1);
            @(posedge clk_sys);
        end
    endtask : hi_len
    task automatic gap(output int n);
        while (fs !== 1'b1) @(posedge clk_sys);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (fs !== 1'b1);
    endtask : gap
    // ====================
    // scenarios
    task automatic t_regs();
        logic [31:0] q;
        sread(REG_TICK, q);
        chk(q, 32'h45);
        sread(REG_FRAME, q);
        chk(q, 32'hc350);
        sread(REG_EXPL, q);
        chk(q, 32'h2710);
        wb(4'he, 1'b0, 32'h0, q);
        chk(q, 32'h0);
        cmd(REG_EXPL, 16'h0001);
        wb(WB_STAT, 1'b0, 32'h0, q);
        chk(q, 32'h1);
        cmd(REG_NFRM, 16'h0000);
        wb(WB_STAT, 1'b0, 32'h0, q);
        chk(q, 32'h1);
        sread(REG_EXPL, q);
        chk(q, 32'h2710);
        cmd(REG_TICK, 16'd10);
        cmd(REG_ROWLEN, 16'd20);
        cmd(REG_WINROWS, 16'd2);
        cmd(REG_GRAN, 16'd1);
        cmd(REG_EXPL, 16'd1000);
        cmd(REG_EXPS, 16'd1100);
        cmd(REG_FRAME, 16'd1200);
        cmd(REG_NFRM, 16'd1);
        $display("test registers done");
    endtask : t_regs
    task automatic t_trig();
        logic [7:0] r0;
        int         n;
        cmd(REG_MODE, {13'h0, MODE_TRIG_INT});
        trig(1'b1);
        trig(1'b0);
        r0 = rem;
        trig(1'b1);
        trig(1'b0);
        chk(rem, r0 + 8'h1);
        chk(cols, 4'h0);
        n = 0;
        repeat (26000) begin
            @(posedge clk_sys);
            n += int'(fs === 1'b1);
        end
        chk(n, 1);
        $display("test triggered done");
    endtask : t_trig
    task automatic t_stream();
        logic [31:0] q;
        int          g, nl, ns, nc, nr, nv, p1, p2, p3;
        cmd(REG_DUAL, 16'h1);
        cmd(REG_PAIR, 16'h0);
        cmd(REG_MODE, {13'h0, MODE_STREAM_INT});
        fork
            gap(g);
            hi_len(1, nl, p1);
            hi_len(2, ns, p2);
            hi_len(3, nc, p3);
            hi_len(4, nr, nv);
        join
        chk(g, 12000);
        chk(nl, 10000);
        chk(ns, 11000);
        chk(nc, 150);
        chk(nr, 140);
        chk(nv, 2);
        chk(cols, 4'h5);
        cmd(REG_PAIR, 16'h1);
        repeat (3) @(posedge clk_sys);
        chk(cols, 4'h3);
        sread(REG_MODE, q);
        chk(q, 32'h3);
        sread(REG_EXPS, q);
        chk(q, 32'd1100);
        hi_len(4, nr, nv);
        chk(nr, 140);
        chk(nv, 2);
        $display("test streaming done");
    endtask : t_stream
    task automatic t_ext();
        int n, p;
        cmd(REG_MODE, {13'h0, MODE_FULL_EXT});
        trig(1'b1);
        chk({exp_l, exp_s}, 2'b10);
        trig(1'b0);
        chk({exp_l, exp_s}, 2'b11);
        cmd(REG_MODE, {13'h0, MODE_PROG_EXT});
        while (exp_l === 1'b1 || exp_s === 1'b1) @(posedge clk_sys);
        fork
            hi_len(1, n, p);
            trig(1'b1);
        join
        chk(n, 10000);
        $display("test external done");
    endtask : t_ext
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        t_regs();
        t_trig();
        t_stream();
        t_ext();
        end_sim();
    end
endmodule : frame_exposure_timing_ctrl_bench
